// *** src/pss_cap_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface pss_cap_if #(parameter int W = 1);
  logic sig;
  logic [W-1:0] pins;
  logic [W-1:0] val;
  logic valid;
  logic taken;
  logic pull_en;
  logic func_en;

  modport samp (input sig, pins, output val, valid, taken, pull_en, func_en);
  modport user (output sig, pins, input val, valid, taken, pull_en, func_en);
endinterface

`default_nettype wire

// *** src/pss_defines.svh ***
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// register offsets, byte addresses on the plain register port
`define PSS_ADDR_W 8
`define PSS_OFF_STATUS 8'h00
`define PSS_OFF_CONTROL 8'h04
`define PSS_OFF_BOOT 8'h08

// status register field positions
`define PSS_ST_SWAP 0
`define PSS_ST_REBOOT 1
`define PSS_ST_DESC 2
`define PSS_ST_TLS 3
`define PSS_ST_DISP3 4
`define PSS_ST_DISP4 5
`define PSS_ST_CPUCLK 6
`define PSS_ST_RSVERR 7
`define PSS_ST_PWRVAL 8
`define PSS_ST_RSMVAL 9

// control register field positions
`define PSS_CT_TS 0
`define PSS_CT_BLK_LO 1
`define PSS_CT_BLK_HI 3

// boot register field positions
`define PSS_BT_CODE_HI 3
`define PSS_BT_FLAG_LO 4
`define PSS_BT_FLAG_HI 9

// platform power-good strap vector
`define PSS_PWR_W 3
`define PSS_PWR_SWAP 0
`define PSS_PWR_REBOOT 1
`define PSS_PWR_DESC 2

// resume-reset strap vector
`define PSS_RSM_W 11
`define PSS_RSM_TLS 0
`define PSS_RSM_BOOT_LO 1
`define PSS_RSM_BOOT_HI 4
`define PSS_RSM_DISP3 5
`define PSS_RSM_DISP4 6
`define PSS_RSM_CPUCLK 7
`define PSS_RSM_FOUT 8
`define PSS_RSM_FD2 9
`define PSS_RSM_FD3 10

// boot-configuration encodings
`define PSS_BOOT_HOST_ESPI 4'h0
`define PSS_BOOT_HOST_NOESPI 4'h2
`define PSS_BOOT_FW_ESPI_HOST 4'h4
`define PSS_BOOT_ESPI_FLASH 4'h8
`define PSS_BOOT_FW_ESPI_DEV 4'hc

// reset values
`define PSS_RST_BLK_SEL 3'h0
`define PSS_RST_TS 1'b0
`define PSS_RST_PULL 1'b1

// strap hold time before the pin returns to its normal function
`define PSS_CLK_MHZ 100
`define PSS_HOLD_US 65
`define PSS_HOLD_CYCLES (`PSS_HOLD_US * `PSS_CLK_MHZ)
`define PSS_HOLD_CNT_W 16

`endif

// *** src/pss_pkg.sv ***
`include "pss_defines.svh"

package pss_pkg;

  typedef struct packed {
    logic host_flash;
    logic espi_en;
    logic fw_on_espi;
    logic eng_on_dev_flash;
    logic espi_flash;
    logic reserved;
  } pss_boot_s;

  typedef logic [`PSS_ADDR_W-1:0] pss_addr_t;

  function automatic pss_boot_s pss_boot_decode(input logic [3:0] code);
    pss_boot_s b;
    b = '0;
    case (code)
      `PSS_BOOT_HOST_ESPI: begin
        b.host_flash = 1'b1;
        b.espi_en = 1'b1;
      end
      `PSS_BOOT_HOST_NOESPI: begin
        b.host_flash = 1'b1;
      end
      `PSS_BOOT_FW_ESPI_HOST: begin
        b.fw_on_espi = 1'b1;
        b.espi_en = 1'b1;
      end
      `PSS_BOOT_ESPI_FLASH: begin
        b.espi_flash = 1'b1;
        b.espi_en = 1'b1;
      end
      `PSS_BOOT_FW_ESPI_DEV: begin
        b.fw_on_espi = 1'b1;
        b.eng_on_dev_flash = 1'b1;
        b.espi_en = 1'b1;
      end
      default: begin
        b.reserved = 1'b1;
      end
    endcase
    return b;
  endfunction

endpackage

// *** src/pss_strap_sampler.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "pss_defines.svh"

module pss_strap_sampler
  import pss_pkg::*;
#(
  parameter int W = 1,
  parameter int unsigned HOLD_CYCLES = `PSS_HOLD_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_ni,
  // sampling group
  pss_cap_if.samp cap
);

  typedef struct packed {
    logic sig;
    logic [W-1:0] val;
    logic valid;
    logic taken;
    logic pull_en;
    logic func_en;
    logic holding;
    logic [`PSS_HOLD_CNT_W-1:0] cnt;
  } pss_smp_st_s;

  localparam logic [`PSS_HOLD_CNT_W-1:0] HOLD_LAST = `PSS_HOLD_CNT_W'(HOLD_CYCLES - 1);

  pss_smp_st_s q, d;
  logic rise;

  assign rise = cap.sig & ~q.sig;

  always_comb begin
    d = q;
    d.sig = cap.sig;
    d.taken = 1'b0;
    if (rise) begin
      d.val = cap.pins; // see RQ1
      d.valid = 1'b1;
      d.taken = 1'b1;
      d.pull_en = 1'b0; // see RQ5
      d.holding = 1'b1;
      d.cnt = '0;
    end else if (!cap.sig) begin
      // value is kept while low, only a new rise replaces it
      d.pull_en = 1'b1;
      d.func_en = 1'b0;
      d.holding = 1'b0;
      d.cnt = '0;
    end else if (q.holding) begin
      if (q.cnt == HOLD_LAST) begin
        d.holding = 1'b0;
        d.func_en = 1'b1; // see RQ1
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      q <= '{sig: 1'b0, val: '0, valid: 1'b0, taken: 1'b0, pull_en: `PSS_RST_PULL,
             func_en: 1'b0, holding: 1'b0, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign cap.val = q.val;
  assign cap.valid = q.valid;
  assign cap.taken = q.taken;
  assign cap.pull_en = q.pull_en;
  assign cap.func_en = q.func_en;

  a_val_held: assert property (@(posedge clk_i) disable iff (!rst_ni) // see RQ14
    !rise |=> $stable(q.val))
    else $error("strap value changed without a sampling edge");

  a_pull_off_edge: assert property (@(posedge clk_i) disable iff (!rst_ni) // see RQ5
    rise |=> (!q.pull_en && q.taken && q.val == $past(cap.pins)))
    else $error("pull not released or value not captured at edge");

  a_func_return: assert property (@(posedge clk_i) disable iff (!rst_ni) // see RQ1
    $rose(q.func_en) |-> ($past(q.cnt) == HOLD_LAST && $past(q.holding)))
    else $error("pin returned to its function before the hold time");

endmodule

`default_nettype wire

// *** src/pss_top.sv ***
// Overview of operation
// RQ1: each strap pin is caught on the rising edge of its sampling signal and afterwards handed back to its normal function.
// RQ2: the swap strap is caught at platform power-good rise and, when high, inverts the selected flash address bit of A[23:16].
// RQ3: while the swap strap is latched high, software cannot clear the swap status bit until the next reboot.
// RQ4: the captured swap strap shows in a software-readable swap status bit.
// RQ5: each strap pin's internal pull is switched off once its sampling signal has gone active.
// RQ6: the reboot suppression strap, caught at platform power-good rise, blocks the system watchdog reboot when high.
// RQ7: the transport security strap, caught at resume-reset rise, enables the engine cipher suite when high.
// RQ8: four pins form the boot code at resume-reset rise, pin 0 giving the least significant bit.
// RQ9: the boot code decodes into the five documented flash arrangements, every other code being reserved.
// RQ10: each display side-band supply strap selects 1.8 V when low and 3.3 V when high, caught at resume-reset rise.
// RQ11: the cpu clock strap, caught at resume-reset rise, selects the direct crystal when low and the board keeps it low.
// RQ12: the board holds the reserved flash data straps high at resume-reset rise.
// RQ13: the descriptor override strap, caught at platform power-good rise, disables descriptor security only when high.
// RQ14: each captured value stays put until its sampling signal falls and rises again.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "pss_defines.svh"

module pss_top
  import pss_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `PSS_HOLD_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // sampling signals
  input wire logic platform_power_good_i,
  input wire logic resume_reset_n_i,
  // platform power-good straps
  input wire logic swap_strap_pin_i,
  input wire logic reboot_suppress_strap_pin_i,
  input wire logic descriptor_override_strap_pin_i,
  // resume-reset straps
  input wire logic transport_security_strap_pin_i,
  input wire logic boot_code_bit0_pin_i,
  input wire logic boot_code_bit1_pin_i,
  input wire logic boot_code_bit2_pin_i,
  input wire logic boot_code_bit3_pin_i,
  input wire logic display3_supply_strap_pin_i,
  input wire logic display4_supply_strap_pin_i,
  input wire logic cpu_clock_source_strap_pin_i,
  input wire logic flash_out_reserved_strap_i,
  input wire logic flash_data2_reserved_strap_i,
  input wire logic flash_data3_reserved_strap_i,
  // register port
  input wire logic [`PSS_ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // pad control
  output logic pwr_pull_en_o,
  output logic pwr_func_en_o,
  output logic rsm_pull_en_o,
  output logic rsm_func_en_o,
  // mode controls
  output logic swap_status_bit_o,
  output logic [7:0] flash_addr_invert_o,
  output logic watchdog_reboot_block_o,
  output logic descriptor_security_en_o,
  output logic tls_cipher_en_o,
  output logic [3:0] boot_code_o,
  output logic boot_host_flash_o,
  output logic boot_espi_en_o,
  output logic boot_fw_on_espi_o,
  output logic boot_eng_on_dev_flash_o,
  output logic boot_espi_flash_o,
  output logic boot_reserved_o,
  output logic display3_3v3_o,
  output logic display4_3v3_o,
  output logic cpu_clk_crystal_o,
  output logic cpu_clk_strap_err_o,
  output logic reserved_strap_err_o
);

  typedef struct packed {
    logic [31:0] rdata;
    logic ts;
    logic [2:0] blk_sel;
    logic [7:0] inv;
    logic reboot_blk;
    logic desc_sec;
    logic tls;
    logic [3:0] boot;
    pss_boot_s flags;
    logic disp3;
    logic disp4;
    logic cpu_xtal;
    logic cpu_err;
    logic rsv_err;
    logic pwr_pull;
    logic pwr_func;
    logic rsm_pull;
    logic rsm_func;
  } pss_top_st_s;

  logic [1:0] rst_sync_q;
  logic rst_n;
  pss_top_st_s q, d;
  logic [31:0] status_w;
  logic [31:0] control_w;
  logic [31:0] boot_w;
  logic swap_locked;

  // reset is released through two flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  pss_cap_if #(.W(`PSS_PWR_W)) pwr_cap ();
  pss_cap_if #(.W(`PSS_RSM_W)) rsm_cap ();

  assign pwr_cap.sig = platform_power_good_i;
  assign pwr_cap.pins = {descriptor_override_strap_pin_i, reboot_suppress_strap_pin_i,
                         swap_strap_pin_i};
  // the resume reset is active low, so its release is the sampling edge
  assign rsm_cap.sig = resume_reset_n_i;
  assign rsm_cap.pins = {flash_data3_reserved_strap_i, flash_data2_reserved_strap_i,
                         flash_out_reserved_strap_i, cpu_clock_source_strap_pin_i,
                         display4_supply_strap_pin_i, display3_supply_strap_pin_i,
                         boot_code_bit3_pin_i, boot_code_bit2_pin_i,
                         boot_code_bit1_pin_i, boot_code_bit0_pin_i,
                         transport_security_strap_pin_i}; // see RQ8

  pss_strap_sampler #(.W(`PSS_PWR_W), .HOLD_CYCLES(HOLD_CYCLES)) u_pwr (
    .clk_i(clk_i),
    .rst_ni(rst_n),
    .cap(pwr_cap.samp)
  );

  pss_strap_sampler #(.W(`PSS_RSM_W), .HOLD_CYCLES(HOLD_CYCLES)) u_rsm (
    .clk_i(clk_i),
    .rst_ni(rst_n),
    .cap(rsm_cap.samp)
  );

  assign swap_locked = pwr_cap.valid & pwr_cap.val[`PSS_PWR_SWAP];

  always_comb begin
    status_w = '0;
    status_w[`PSS_ST_SWAP] = pwr_cap.val[`PSS_PWR_SWAP];
    status_w[`PSS_ST_REBOOT] = pwr_cap.val[`PSS_PWR_REBOOT];
    status_w[`PSS_ST_DESC] = pwr_cap.val[`PSS_PWR_DESC];
    status_w[`PSS_ST_TLS] = rsm_cap.val[`PSS_RSM_TLS];
    status_w[`PSS_ST_DISP3] = rsm_cap.val[`PSS_RSM_DISP3];
    status_w[`PSS_ST_DISP4] = rsm_cap.val[`PSS_RSM_DISP4];
    status_w[`PSS_ST_CPUCLK] = rsm_cap.val[`PSS_RSM_CPUCLK];
    status_w[`PSS_ST_RSVERR] = q.rsv_err;
    status_w[`PSS_ST_PWRVAL] = pwr_cap.valid;
    status_w[`PSS_ST_RSMVAL] = rsm_cap.valid;
    control_w = '0;
    control_w[`PSS_CT_TS] = q.ts; // see RQ4
    control_w[`PSS_CT_BLK_HI:`PSS_CT_BLK_LO] = q.blk_sel;
    boot_w = '0;
    boot_w[`PSS_BT_CODE_HI:0] = q.boot;
    boot_w[`PSS_BT_FLAG_HI:`PSS_BT_FLAG_LO] = q.flags;
  end

  always_comb begin
    d = q;
    // register port
    d.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        `PSS_OFF_STATUS: d.rdata = status_w;
        `PSS_OFF_CONTROL: d.rdata = control_w;
        `PSS_OFF_BOOT: d.rdata = boot_w;
        default: d.rdata = '0;
      endcase
    end
    if (wr_i && addr_i == `PSS_OFF_CONTROL) begin
      d.blk_sel = wdata_i[`PSS_CT_BLK_HI:`PSS_CT_BLK_LO];
      if (!swap_locked) begin
        d.ts = wdata_i[`PSS_CT_TS];
      end // see RQ3
    end
    // a fresh capture wins over a write in the same cycle
    if (pwr_cap.taken) begin
      d.ts = pwr_cap.val[`PSS_PWR_SWAP]; // see RQ2
    end
    d.inv = q.ts ? (8'h01 << q.blk_sel) : 8'h00; // see RQ2
    d.reboot_blk = pwr_cap.valid & pwr_cap.val[`PSS_PWR_REBOOT]; // see RQ6
    d.desc_sec = ~(pwr_cap.valid & pwr_cap.val[`PSS_PWR_DESC]); // see RQ13
    d.tls = rsm_cap.valid & rsm_cap.val[`PSS_RSM_TLS]; // see RQ7
    d.boot = rsm_cap.val[`PSS_RSM_BOOT_HI:`PSS_RSM_BOOT_LO]; // see RQ8
    d.flags = pss_boot_decode(rsm_cap.val[`PSS_RSM_BOOT_HI:`PSS_RSM_BOOT_LO]); // see RQ9
    d.disp3 = rsm_cap.val[`PSS_RSM_DISP3]; // see RQ10
    d.disp4 = rsm_cap.val[`PSS_RSM_DISP4]; // see RQ10
    d.cpu_xtal = ~rsm_cap.val[`PSS_RSM_CPUCLK]; // see RQ11
    d.cpu_err = rsm_cap.valid & rsm_cap.val[`PSS_RSM_CPUCLK]; // see RQ11
    // flags a board that pulled a reserved flash strap low
    d.rsv_err = rsm_cap.valid & ~(rsm_cap.val[`PSS_RSM_FOUT] & rsm_cap.val[`PSS_RSM_FD2] &
                                  rsm_cap.val[`PSS_RSM_FD3]); // see RQ12
    d.pwr_pull = pwr_cap.pull_en; // see RQ5
    d.pwr_func = pwr_cap.func_en; // see RQ1
    d.rsm_pull = rsm_cap.pull_en; // see RQ5
    d.rsm_func = rsm_cap.func_en; // see RQ1
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ts <= `PSS_RST_TS;
      q.blk_sel <= `PSS_RST_BLK_SEL;
      q.desc_sec <= 1'b1;
      q.cpu_xtal <= 1'b1;
      q.flags <= pss_boot_decode(4'h0);
      q.pwr_pull <= `PSS_RST_PULL;
      q.rsm_pull <= `PSS_RST_PULL;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign pwr_pull_en_o = q.pwr_pull;
  assign pwr_func_en_o = q.pwr_func;
  assign rsm_pull_en_o = q.rsm_pull;
  assign rsm_func_en_o = q.rsm_func;
  assign swap_status_bit_o = q.ts;
  assign flash_addr_invert_o = q.inv;
  assign watchdog_reboot_block_o = q.reboot_blk;
  assign descriptor_security_en_o = q.desc_sec;
  assign tls_cipher_en_o = q.tls;
  assign boot_code_o = q.boot;
  assign boot_host_flash_o = q.flags.host_flash;
  assign boot_espi_en_o = q.flags.espi_en;
  assign boot_fw_on_espi_o = q.flags.fw_on_espi;
  assign boot_eng_on_dev_flash_o = q.flags.eng_on_dev_flash;
  assign boot_espi_flash_o = q.flags.espi_flash;
  assign boot_reserved_o = q.flags.reserved;
  assign display3_3v3_o = q.disp3;
  assign display4_3v3_o = q.disp4;
  assign cpu_clk_crystal_o = q.cpu_xtal;
  assign cpu_clk_strap_err_o = q.cpu_err;
  assign reserved_strap_err_o = q.rsv_err;

  sequence s_pwr_rise;
    !platform_power_good_i ##1 platform_power_good_i;
  endsequence

  sequence s_rsm_rise;
    !resume_reset_n_i ##1 resume_reset_n_i;
  endsequence

  sequence s_clear_try;
    wr_i && addr_i == `PSS_OFF_CONTROL && !wdata_i[`PSS_CT_TS];
  endsequence

  a_swap_capture: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ4
    s_pwr_rise |-> ##2 (q.ts == $past(swap_strap_pin_i, 2)))
    else $error("swap status does not follow the swap strap");

  a_swap_sticky: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ3
    (s_clear_try and (swap_locked && q.ts)) |=> q.ts)
    else $error("swap status cleared while the strap holds it");

  a_swap_invert: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ2
    q.ts && $stable(q.ts) && $stable(q.blk_sel) |-> q.inv == (8'h01 << q.blk_sel))
    else $error("flash address inversion mask wrong");

  a_reboot_block: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ6
    s_pwr_rise |-> ##3 (watchdog_reboot_block_o == $past(reboot_suppress_strap_pin_i, 3)))
    else $error("watchdog reboot block does not follow its strap");

  a_desc_security: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ13
    s_pwr_rise |-> ##3 (descriptor_security_en_o != $past(descriptor_override_strap_pin_i, 3)))
    else $error("descriptor security does not follow its strap");

  a_tls_enable: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ7
    s_rsm_rise |-> ##3 (tls_cipher_en_o == $past(transport_security_strap_pin_i, 3)))
    else $error("cipher enable does not follow its strap");

  a_boot_code: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ8
    s_rsm_rise |-> ##3 (boot_code_o == {$past(boot_code_bit3_pin_i, 3),
      $past(boot_code_bit2_pin_i, 3), $past(boot_code_bit1_pin_i, 3),
      $past(boot_code_bit0_pin_i, 3)}))
    else $error("boot code bits out of order");

  a_boot_decode: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ9
    $stable(q.boot) |-> (q.flags == pss_boot_decode(q.boot)))
    else $error("boot flags do not match the boot code");

  a_display_supply: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ10
    s_rsm_rise |-> ##3 (display3_3v3_o == $past(display3_supply_strap_pin_i, 3) &&
      display4_3v3_o == $past(display4_supply_strap_pin_i, 3)))
    else $error("display supply select does not follow its straps");

  a_cpu_clock: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ11
    s_rsm_rise |-> ##3 (cpu_clk_crystal_o != $past(cpu_clock_source_strap_pin_i, 3)))
    else $error("cpu clock source does not follow its strap");

  a_pull_release: assert property (@(posedge clk_i) disable iff (!rst_n) // see RQ5
    s_rsm_rise |-> ##2 !rsm_pull_en_o [*2])
    else $error("resume straps still pulled after sampling");

endmodule

`default_nettype wire

// *** tb/pss_board_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pss_board_model (
  // clock
  input wire logic clk_i,
  // board settings
  input wire logic [2:0] pwr_board_i,
  input wire logic [10:0] rsm_board_i,
  input wire logic fault_i,
  // pad state from the block
  input wire logic pwr_func_en_i,
  input wire logic rsm_func_en_i,
  // strap pins
  output logic [2:0] pwr_pins_o,
  output logic [10:0] rsm_pins_o
);
  // ordinary pin traffic once the straps are handed back
  logic [10:0] traffic_q = 11'h2a5;

  always @(posedge clk_i) begin
    traffic_q <= ~traffic_q;
  end

  always_comb begin
    rsm_pins_o = rsm_board_i;
    if (!fault_i) begin
      rsm_pins_o[7] = 1'b0;
      rsm_pins_o[10:8] = 3'h7;
    end
    if (rsm_func_en_i) begin
      rsm_pins_o = traffic_q;
    end
    pwr_pins_o = pwr_func_en_i ? traffic_q[2:0] : pwr_board_i;
  end
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pss_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic pg = 1'b0;
  logic rsmn = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] pwr_board = 3'h0;
  logic [10:0] rsm_board = 11'h0;
  logic fault = 1'b0;
  logic [2:0] pwr_pins;
  logic [10:0] rsm_pins;
  logic [31:0] rdata;
  logic pwr_pull, pwr_func, rsm_pull, rsm_func, ts, wdog, desc_sec, tls;
  logic host, espi, fw, eng, espif, resv, d3, d4, xtal, cpu_err, rsv_err;
  logic [7:0] inv;
  logic [3:0] code;
  int errors = 0;
  int checks_done = 0;

  always #5 clk_i = ~clk_i;

  pss_board_model u_board (.clk_i(clk_i), .pwr_board_i(pwr_board), .rsm_board_i(rsm_board),
    .fault_i(fault), .pwr_func_en_i(pwr_func), .rsm_func_en_i(rsm_func),
    .pwr_pins_o(pwr_pins), .rsm_pins_o(rsm_pins));

  pss_top #(.HOLD_CYCLES(8)) u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .platform_power_good_i(pg), .resume_reset_n_i(rsmn),
    .swap_strap_pin_i(pwr_pins[0]), .reboot_suppress_strap_pin_i(pwr_pins[1]),
    .descriptor_override_strap_pin_i(pwr_pins[2]),
    .transport_security_strap_pin_i(rsm_pins[0]), .boot_code_bit0_pin_i(rsm_pins[1]),
    .boot_code_bit1_pin_i(rsm_pins[2]), .boot_code_bit2_pin_i(rsm_pins[3]),
    .boot_code_bit3_pin_i(rsm_pins[4]), .display3_supply_strap_pin_i(rsm_pins[5]),
    .display4_supply_strap_pin_i(rsm_pins[6]), .cpu_clock_source_strap_pin_i(rsm_pins[7]),
    .flash_out_reserved_strap_i(rsm_pins[8]), .flash_data2_reserved_strap_i(rsm_pins[9]),
    .flash_data3_reserved_strap_i(rsm_pins[10]),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .pwr_pull_en_o(pwr_pull), .pwr_func_en_o(pwr_func), .rsm_pull_en_o(rsm_pull),
    .rsm_func_en_o(rsm_func), .swap_status_bit_o(ts), .flash_addr_invert_o(inv),
    .watchdog_reboot_block_o(wdog), .descriptor_security_en_o(desc_sec),
    .tls_cipher_en_o(tls), .boot_code_o(code), .boot_host_flash_o(host),
    .boot_espi_en_o(espi), .boot_fw_on_espi_o(fw), .boot_eng_on_dev_flash_o(eng),
    .boot_espi_flash_o(espif), .boot_reserved_o(resv), .display3_3v3_o(d3),
    .display4_3v3_o(d4), .cpu_clk_crystal_o(xtal), .cpu_clk_strap_err_o(cpu_err),
    .reserved_strap_err_o(rsv_err));

  task automatic stop_test();
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata;
  endtask

  // raise one sampling signal, check the pad hand-over; grp 1 is platform power-good
  task automatic sample(input logic grp);
    int n;
    @(posedge clk_i);
    if (grp) pg <= 1'b1;
    else rsmn <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk(grp ? pwr_pull : rsm_pull, 1'b0, "pull still on");
    chk(grp ? pwr_func : rsm_func, 1'b0, "pin released early");
    n = 0;
    while ((grp ? pwr_func : rsm_func) !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(n < 40, 1, "pin never returned");
    if (n >= 40) stop_test();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic drop(input logic grp);
    @(posedge clk_i);
    if (grp) pg <= 1'b0;
    else rsmn <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk({grp ? pwr_pull : rsm_pull, grp ? pwr_func : rsm_func}, 2'h2, "pull not back");
  endtask

  function automatic logic [5:0] exp_flags(input logic [3:0] c);
    case (c)
      4'h0: return 6'h30;
      4'h2: return 6'h20;
      4'h4: return 6'h18;
      4'h8: return 6'h12;
      4'hc: return 6'h1c;
      default: return 6'h01;
    endcase
  endfunction

  task automatic test_reset();
    chk({pwr_pull, rsm_pull, pwr_func, rsm_func}, 4'hc, "reset pads");
    chk({ts, inv, wdog}, 10'h0, "reset swap");
    chk(desc_sec, 1'b1, "reset descriptor");
  endtask

  task automatic test_resume();
    logic [3:0] codes [7] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'hc, 4'h1, 4'hf};
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      fault <= (i == 6);
      rsm_board <= {3'h5, 1'b1, i[1], i[0], codes[i], i[2]};
      sample(1'b0);
      chk(code, codes[i], "boot code");
      chk({host, espi, fw, eng, espif, resv}, exp_flags(codes[i]), "boot decode");
      chk(tls, i[2], "cipher enable");
      chk({d4, d3}, i[1:0], "display supply");
      chk({xtal, cpu_err}, (i == 6) ? 2'h1 : 2'h2, "cpu clock");
      chk(rsv_err, i == 6, "reserved straps");
      reg_rd(8'h08, d);
      chk(d[9:0], {exp_flags(codes[i]), codes[i]}, "boot register");
      reg_rd(8'h00, d);
      chk({d[9], d[7:3]}, {1'b1, i == 6, i == 6, i[1:0], i[2]}, "status resume");
      drop(1'b0);
    end
    fault <= 1'b0;
  endtask

  task automatic test_power();
    logic [31:0] d;
    for (int s = 1; s >= 0; s--) begin
      pwr_board <= {3{s[0]}};
      sample(1'b1);
      chk(ts, s[0], "swap status");
      chk(inv, s[0] ? 8'h01 : 8'h00, "address invert");
      chk({wdog, desc_sec}, {s[0], ~s[0]}, "reboot and descriptor");
      reg_rd(8'h00, d);
      chk({d[8], d[2:0]}, {1'b1, {3{s[0]}}}, "status power");
      reg_wr(8'h04, 32'h0);
      #1 chk(ts, s[0], "swap clear");
      reg_wr(8'h04, 32'h7);
      reg_wr(8'h04, 32'h6);
      repeat (2) @(posedge clk_i);
      #1 chk(inv, s[0] ? 8'h08 : 8'h00, "block select");
      reg_rd(8'h04, d);
      chk(d[3:0], {3'h3, s[0]}, "control readback");
      chk({ts, wdog}, {2{s[0]}}, "capture held");
      drop(1'b1);
    end
    reg_wr(8'h0c, 32'hffff);
    reg_rd(8'h0c, d);
    chk(d, 32'h0, "unmapped read");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    test_reset();
    test_resume();
    test_power();
    stop_test();
  end
endmodule

`default_nettype wire
